// ### verilog/rcmr_regs.sv
// Radio-core misc control register bank with an AXI4-Lite slave port.
`timescale 1ns/1ns
module rcmr_regs
   import rcmr_pkg::*;
(
   input wire logic clk, // System clock, 250 MHz.
   input wire logic sys_rst, // Synchronous reset, active high.
   // AXI4-Lite write address channel.
   input wire logic [RCMR_ADDR_W-1:0] s_axi_awaddr, // Write byte address.
   input wire logic [2:0] s_axi_awprot, // Protection, unused.
   input wire logic s_axi_awvalid, // Write address valid.
   output logic s_axi_awready, // Write address ready.
   // AXI4-Lite write data channel.
   input wire logic [RCMR_DATA_W-1:0] s_axi_wdata, // Write data.
   input wire logic [RCMR_STRB_W-1:0] s_axi_wstrb, // Byte strobes.
   input wire logic s_axi_wvalid, // Write data valid.
   output logic s_axi_wready, // Write data ready.
   // AXI4-Lite write response channel.
   output logic [1:0] s_axi_bresp, // Write response.
   output logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   // AXI4-Lite read channels.
   input wire logic [RCMR_ADDR_W-1:0] s_axi_araddr, // Read byte address.
   input wire logic [2:0] s_axi_arprot, // Protection, unused.
   input wire logic s_axi_arvalid, // Read address valid.
   output logic s_axi_arready, // Read address ready.
   output logic [RCMR_DATA_W-1:0] s_axi_rdata, // Read data.
   output logic [1:0] s_axi_rresp, // Read response.
   output logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   // Radio-core observation sources.
   input wire logic [RCMR_SRC_N-1:0] radioCoreSignals, // Generic sources.
   input wire logic txActive, // Transmitter active.
   input wire logic rxActive, // Receiver active.
   input wire logic engineIdleIn, // Engine reports idle.
   output logic observeOut1, // Observation output 1.
   output logic observeOut2, // Observation output 2.
   // Link-layer engine control.
   output logic engineReset, // Engine held in reset.
   output rcmr_mode_t engineMode, // Mode the engine runs in.
   output logic engineModeProprietary, // Mode decode: proprietary.
   output logic engineModeLowEnergy, // Mode decode: low-energy stack.
   output logic engineModeReserved, // Mode decode: reserved code.
   // Radio datapath settings.
   output logic [1:0] txFilterBandwidth, // Anti-aliasing filter code.
   input wire logic [RCMR_REG_W-1:0] randomBitsIn, // Raw random bits.
   input wire logic randomValid, // Receiver running without sync.
   output logic [RCMR_PAGE_W-1:0] radioMemoryPage // Active data memory page.
);

   // ------------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------------
   rcmr_obs_ctrl_t obsCtrl1_r;
   rcmr_obs_ctrl_t obsCtrl2_r;
   rcmr_engine_ctrl_t engineCtrl_r;
   rcmr_filter_cfg_t filterCfg_r;
   logic [RCMR_REG_W-1:0] randomBits_r;
   logic [RCMR_PAGE_W-1:0] memPage_r;
   rcmr_eng_state_t engState_r;
   rcmr_mode_t activeMode_r;

   // ------------------------------------------------------------------
   // Write channel state
   // ------------------------------------------------------------------
   logic awHeld_r;
   logic wHeld_r;
   logic [RCMR_IDX_W-1:0] wrIdx_r;
   logic [RCMR_REG_W-1:0] wrData_r;
   logic wrLane0_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic doWrite;
   logic wrMapped;
   logic [RCMR_REG_W-1:0] wrByte;

   // ------------------------------------------------------------------
   // Read channel state
   // ------------------------------------------------------------------
   logic rvalid_r;
   logic [RCMR_DATA_W-1:0] rdata_r;
   logic [1:0] rresp_r;
   logic [RCMR_IDX_W-1:0] rdIdx;
   logic [RCMR_REG_W-1:0] rdByte;
   logic rdMapped;

   // ------------------------------------------------------------------
   // Write address and data capture
   // ------------------------------------------------------------------
   // Address and data are taken independently, in either order; each
   // channel stays blocked until the pending write has been answered.
   assign s_axi_awready = ~awHeld_r;
   assign s_axi_wready = ~wHeld_r;
   assign doWrite = awHeld_r & wHeld_r & ~bvalid_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         awHeld_r <= 1'b0;
         wrIdx_r <= '0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         awHeld_r <= 1'b1;
         wrIdx_r <= s_axi_awaddr[RCMR_ADDR_W-1:RCMR_IDX_LSB];
      end else if (doWrite) begin
         awHeld_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wHeld_r <= 1'b0;
         wrData_r <= '0;
         wrLane0_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         wHeld_r <= 1'b1;
         wrData_r <= s_axi_wdata[RCMR_REG_W-1:0];
         wrLane0_r <= s_axi_wstrb[0];
      end else if (doWrite) begin
         wHeld_r <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   always_comb begin
      case (wrIdx_r)
         RCMR_IDX_OBS1, RCMR_IDX_OBS2, RCMR_IDX_ENGINE,
         RCMR_IDX_FILTER, RCMR_IDX_RANDOM, RCMR_IDX_PAGE: begin
            wrMapped = 1'b1;
         end
         default: begin
            wrMapped = 1'b0;
         end
      endcase
   end

   assign wrByte = wrData_r;

   // ------------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------------
   // Writes to the read-only random byte answer OKAY and change nothing;
   // only an address outside the bank answers SLVERR.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         bvalid_r <= 1'b0;
         bresp_r <= RCMR_RESP_OKAY;
      end else if (doWrite) begin
         bvalid_r <= 1'b1;
         bresp_r <= wrMapped ? RCMR_RESP_OKAY : RCMR_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // ------------------------------------------------------------------
   // Observation control registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         obsCtrl1_r <= RCMR_OBS_RST;
      end else if (doWrite && wrLane0_r && wrIdx_r == RCMR_IDX_OBS1) begin
         obsCtrl1_r <= wrByte[RCMR_SEL_W:0];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         obsCtrl2_r <= RCMR_OBS_RST;
      end else if (doWrite && wrLane0_r && wrIdx_r == RCMR_IDX_OBS2) begin
         obsCtrl2_r <= wrByte[RCMR_SEL_W:0];
      end
   end

   // ------------------------------------------------------------------
   // Engine control register
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         engineCtrl_r <= RCMR_ENGINE_RST;
      end else if (doWrite && wrLane0_r && wrIdx_r == RCMR_IDX_ENGINE) begin
         engineCtrl_r <= rcmr_engine_ctrl_t'(wrByte[2:0]);
      end
   end

   // The engine only samples its mode when it leaves reset, so the mode
   // is latched on the enable rising edge and ignored otherwise.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         engState_r <= RCMR_ENG_HELD;
         activeMode_r <= RCMR_MODE_PROPRIETARY;
      end else begin
         case (engState_r)
            RCMR_ENG_HELD: begin
               if (engineCtrl_r.enable) begin
                  engState_r <= RCMR_ENG_RUN;
                  activeMode_r <= engineCtrl_r.mode;
               end
            end
            RCMR_ENG_RUN: begin
               if (!engineCtrl_r.enable) begin
                  engState_r <= RCMR_ENG_HELD;
               end
            end
            default: begin
               engState_r <= RCMR_ENG_HELD;
            end
         endcase
      end
   end

   assign engineReset = (engState_r == RCMR_ENG_HELD);
   assign engineMode = activeMode_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         engineModeProprietary <= 1'b1;
         engineModeLowEnergy <= 1'b0;
         engineModeReserved <= 1'b0;
      end else begin
         engineModeProprietary <= (activeMode_r == RCMR_MODE_PROPRIETARY);
         engineModeLowEnergy <= (activeMode_r == RCMR_MODE_LOW_ENERGY);
         engineModeReserved <= (activeMode_r == RCMR_MODE_RSVD_2) ||
                               (activeMode_r == RCMR_MODE_RSVD_3);
      end
   end

   // ------------------------------------------------------------------
   // Filter, random byte and memory page
   // ------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         filterCfg_r <= RCMR_FILTER_RST;
      end else if (doWrite && wrLane0_r && wrIdx_r == RCMR_IDX_FILTER) begin
         filterCfg_r <= wrByte[3:0];
      end
   end

   assign txFilterBandwidth = filterCfg_r.bandwidth;

   // Samples are only refreshed while the receiver free-runs without
   // sync; otherwise the last good byte is kept rather than noise.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         randomBits_r <= RCMR_RANDOM_RST;
      end else if (randomValid) begin
         randomBits_r <= randomBitsIn;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         memPage_r <= RCMR_PAGE_RST;
      end else if (doWrite && wrLane0_r && wrIdx_r == RCMR_IDX_PAGE) begin
         memPage_r <= wrByte[RCMR_PAGE_W-1:0];
      end
   end

   assign radioMemoryPage = memPage_r;

   // ------------------------------------------------------------------
   // Observation multiplexers
   // ------------------------------------------------------------------
   logic [RCMR_SRC_N-1:0] obsSources;

   // An engine in reset is never idle, whatever its own flag says.
   always_comb begin
      obsSources = radioCoreSignals;
      obsSources[RCMR_SEL_TX_ACTIVE] = txActive;
      obsSources[RCMR_SEL_RX_ACTIVE] = rxActive;
      obsSources[RCMR_SEL_ENGINE_IDLE] = engineIdleIn & ~engineReset;
   end

   rcmr_obs_mux #(
      .SRC_N(RCMR_SRC_N),
      .SEL_W(RCMR_SEL_W)
   ) u_obs_mux_1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .sources(obsSources),
      .select(obsCtrl1_r.select),
      .invert(obsCtrl1_r.invert),
      .obsOut(observeOut1)
   );

   rcmr_obs_mux #(
      .SRC_N(RCMR_SRC_N),
      .SEL_W(RCMR_SEL_W)
   ) u_obs_mux_2 (
      .clk(clk),
      .sys_rst(sys_rst),
      .sources(obsSources),
      .select(obsCtrl2_r.select),
      .invert(obsCtrl2_r.invert),
      .obsOut(observeOut2)
   );

   // ------------------------------------------------------------------
   // Read decode
   // ------------------------------------------------------------------
   assign rdIdx = s_axi_araddr[RCMR_ADDR_W-1:RCMR_IDX_LSB];

   always_comb begin
      rdByte = '0;
      rdMapped = 1'b1;
      case (rdIdx)
         RCMR_IDX_OBS1: begin
            rdByte = {1'b0, obsCtrl1_r};
         end
         RCMR_IDX_OBS2: begin
            rdByte = {1'b0, obsCtrl2_r};
         end
         RCMR_IDX_ENGINE: begin
            rdByte = {5'h00, engineCtrl_r};
         end
         RCMR_IDX_FILTER: begin
            rdByte = {4'h0, filterCfg_r};
         end
         RCMR_IDX_RANDOM: begin
            rdByte = randomBits_r;
         end
         RCMR_IDX_PAGE: begin
            rdByte = {RCMR_PAGE_RSVD_VAL, memPage_r};
         end
         default: begin
            rdMapped = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Read response
   // ------------------------------------------------------------------
   // One read is outstanding at a time; a new address is only taken
   // once the previous data has been accepted.
   assign s_axi_arready = ~rvalid_r;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RCMR_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rdata_r <= {{(RCMR_DATA_W-RCMR_REG_W){1'b0}}, rdByte};
         rresp_r <= rdMapped ? RCMR_RESP_OKAY : RCMR_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

endmodule : rcmr_regs

// ### pkg/rcmr_pkg.sv
// Constants, field layouts and carrier types of the radio-core control register bank.
// How it works
// - Output 1 is selector-1 signal XOR invert.
// - Six-bit select field 1, bits 5:0, resets zero.
// - Output 2 is selector-2 signal XOR invert.
// - Six-bit select field 2, bits 5:0, resets zero.
// - Codes 09 tx, 0A rx, 0D engine idle.
// - New mode applies only on enable rising.
// - Mode 00 proprietary, 01 low energy, others reserved.
// - Enable low holds engine reset; high runs.
// - Filter bandwidth code bits 1:0, resets 11.
// - Random byte read-only, valid without sync.
// - Memory page field bits 2:0, resets 000.
package rcmr_pkg;

   // ------
   // Bus and data widths
   // ------
   localparam int RCMR_DATA_W = 32;
   localparam int RCMR_STRB_W = 4;
   localparam int RCMR_ADDR_W = 18;
   localparam int RCMR_IDX_W = 16;
   localparam int RCMR_IDX_LSB = 2;
   localparam int RCMR_REG_W = 8;
   localparam int RCMR_SEL_W = 6;
   localparam int RCMR_SRC_N = 64;
   localparam int RCMR_PAGE_W = 3;

   // ------
   // Register indices; the byte address is four times the index
   // ------
   localparam logic [15:0] RCMR_IDX_OBS1 = 16'h61AF;
   localparam logic [15:0] RCMR_IDX_OBS2 = 16'h61B0;
   localparam logic [15:0] RCMR_IDX_ENGINE = 16'h61B1;
   localparam logic [15:0] RCMR_IDX_FILTER = 16'h61BC;
   localparam logic [15:0] RCMR_IDX_RANDOM = 16'h61BF;
   localparam logic [15:0] RCMR_IDX_PAGE = 16'h61C0;

   // ------
   // Observation source codes with a dedicated source
   // ------
   localparam logic [5:0] RCMR_SEL_TX_ACTIVE = 6'h09;
   localparam logic [5:0] RCMR_SEL_RX_ACTIVE = 6'h0A;
   localparam logic [5:0] RCMR_SEL_ENGINE_IDLE = 6'h0D;

   // ------
   // Carrier types and reset values
   // ------
   typedef struct packed {
      logic invert;
      logic [5:0] select;
   } rcmr_obs_ctrl_t;

   typedef enum logic [1:0] {
      RCMR_MODE_PROPRIETARY = 2'b00,
      RCMR_MODE_LOW_ENERGY = 2'b01,
      RCMR_MODE_RSVD_2 = 2'b10,
      RCMR_MODE_RSVD_3 = 2'b11
   } rcmr_mode_t;

   typedef struct packed {
      rcmr_mode_t mode;
      logic enable;
   } rcmr_engine_ctrl_t;

   typedef struct packed {
      logic [1:0] spare;
      logic [1:0] bandwidth;
   } rcmr_filter_cfg_t;

   typedef enum logic [0:0] {
      RCMR_ENG_HELD = 1'b0,
      RCMR_ENG_RUN = 1'b1
   } rcmr_eng_state_t;

   localparam rcmr_obs_ctrl_t RCMR_OBS_RST = '{invert: 1'b0, select: 6'h00};
   localparam rcmr_engine_ctrl_t RCMR_ENGINE_RST = '{mode: RCMR_MODE_PROPRIETARY, enable: 1'b0};
   localparam rcmr_filter_cfg_t RCMR_FILTER_RST = '{spare: 2'h3, bandwidth: 2'h3};
   localparam logic [7:0] RCMR_RANDOM_RST = 8'h00;
   localparam logic [2:0] RCMR_PAGE_RST = 3'h0;
   localparam logic [4:0] RCMR_PAGE_RSVD_VAL = 5'h01;

   // ------
   // Bus responses
   // ------
   localparam logic [1:0] RCMR_RESP_OKAY = 2'b00;
   localparam logic [1:0] RCMR_RESP_SLVERR = 2'b10;

endpackage : rcmr_pkg

// ### verilog/rcmr_obs_mux.sv
// One observation multiplexer with polarity invert and a registered output.
`timescale 1ns/1ns
module rcmr_obs_mux
   import rcmr_pkg::*;
#(
   parameter int SRC_N = RCMR_SRC_N,
   parameter int SEL_W = RCMR_SEL_W
) (
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Synchronous reset, active high.
   input wire logic [SRC_N-1:0] sources, // Candidate radio-core signals.
   input wire logic [SEL_W-1:0] select, // Source code.
   input wire logic invert, // Polarity invert.
   output logic obsOut // Observed signal, registered.
);

   // ------------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------------
   // The output is registered so that the pin never shows a mux glitch
   // while software rewrites the select field.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         obsOut <= 1'b0;
      end else begin
         obsOut <= sources[select] ^ invert;
      end
   end

endmodule : rcmr_obs_mux

// ### verification/rcmr_regs_checker.sv
// Concurrent checks on the ports of the radio-core control register bank.
`timescale 1ns/1ns
module rcmr_regs_checker
   import rcmr_pkg::*;
(
   input wire logic clk, // System clock.
   input wire logic sys_rst, // Synchronous reset.
   input wire logic s_axi_awvalid, // Write address valid.
   input wire logic s_axi_awready, // Write address ready.
   input wire logic s_axi_wvalid, // Write data valid.
   input wire logic s_axi_wready, // Write data ready.
   input wire logic [1:0] s_axi_bresp, // Write response.
   input wire logic s_axi_bvalid, // Write response valid.
   input wire logic s_axi_bready, // Write response ready.
   input wire logic s_axi_arvalid, // Read address valid.
   input wire logic s_axi_arready, // Read address ready.
   input wire logic [RCMR_DATA_W-1:0] s_axi_rdata, // Read data.
   input wire logic s_axi_rvalid, // Read data valid.
   input wire logic s_axi_rready, // Read data ready.
   input wire logic engineReset, // Engine held in reset.
   input wire rcmr_mode_t engineMode, // Engine mode.
   input wire logic engineModeProprietary, // Proprietary decode.
   input wire logic engineModeLowEnergy, // Low-energy decode.
   input wire logic engineModeReserved, // Reserved decode.
   input wire logic [1:0] txFilterBandwidth, // Filter code.
   input wire logic [RCMR_PAGE_W-1:0] radioMemoryPage // Memory page.
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   // ------
   // Bus steps
   // ------
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   // No write was applied at the edge before this one.
   sequence s_quiet;
      !$rose(s_axi_bvalid);
   endsequence

   property p_wr_answer;
      s_wr_taken |-> ##2 s_axi_bvalid;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && !s_axi_arready;
   endproperty
   property p_rd_upper;
      s_rd_taken |=> s_axi_rvalid && (s_axi_rdata[31:8] == 24'h0);
   endproperty
   property p_mode_decode;
      engineModeProprietary == ($past(engineMode) == RCMR_MODE_PROPRIETARY) &&
      engineModeLowEnergy == ($past(engineMode) == RCMR_MODE_LOW_ENERGY) &&
      engineModeReserved == $past(engineMode[1]);
   endproperty
   property p_mode_frozen;
      !engineReset && !$past(engineReset) |-> $stable(engineMode);
   endproperty
   property p_reset_follows_write;
      $changed(engineReset) |-> $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
   endproperty
   property p_filter_stable;
      s_quiet |-> $stable(txFilterBandwidth);
   endproperty
   property p_page_stable;
      s_quiet |-> $stable(radioMemoryPage);
   endproperty

   a_wr_answer: assert property (p_wr_answer)
      else $error("write answer late");
   a_b_hold: assert property (p_b_hold)
      else $error("write response dropped");
   a_r_hold: assert property (p_r_hold)
      else $error("read data dropped");
   a_rd_upper: assert property (p_rd_upper)
      else $error("read upper bits set");
   a_mode_decode: assert property (p_mode_decode)
      else $error("mode decode wrong");
   a_mode_frozen: assert property (p_mode_frozen)
      else $error("mode changed while running");
   a_reset_follows_write: assert property (p_reset_follows_write)
      else $error("engine reset moved without write");
   a_filter_stable: assert property (p_filter_stable)
      else $error("filter code moved without write");
   a_page_stable: assert property (p_page_stable)
      else $error("page moved without write");
endmodule : rcmr_regs_checker

// ### verification/tb.sv
// Self-checking testbench for the radio-core control register bank.
`timescale 1ns/1ns
module tb
   import rcmr_pkg::*;
;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [RCMR_ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [63:0] radioCoreSignals = 64'h8000_0000_0000_0020;
   logic txActive = 1'b1, rxActive = 1'b0, engineIdleIn = 1'b1, randomValid = 1'b0;
   logic [7:0] randomBitsIn = 8'h00;
   logic observeOut1, observeOut2, engineReset;
   logic engineModeProprietary, engineModeLowEnergy, engineModeReserved;
   rcmr_mode_t engineMode;
   logic [1:0] txFilterBandwidth;
   logic [2:0] radioMemoryPage;
   int nErrors = 0, totalChecks = 0;

   always #2 clk = ~clk;

   rcmr_regs rcmr_regs_inst (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0));

   // ------
   // Reporting
   // ------
   task automatic endOfTest();
      $display("Checks %0d, errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : endOfTest

   task automatic check(input logic [31:0] seen, exp);
      totalChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic hang();
      nErrors++;
      $display("Error at %0t ns: bus answer never came", $time);
      endOfTest();
   endtask : hang

   // ------
   // Bus master
   // ------
   // Ready waits for valid, so the slave must hold its answer.
   task automatic axiWrite(input logic [15:0] idx, input logic [7:0] d,
                           input logic [3:0] st, output logic [1:0] resp);
      int n;
      @(posedge clk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
      end
      if (n == 40) hang();
   endtask : axiWrite

   task automatic axiRead(input logic [15:0] idx, output logic [31:0] d,
                          output logic [1:0] resp);
      int n;
      @(posedge clk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
      end
      if (n == 40) hang();
   endtask : axiRead

   task automatic writeOk(input logic [15:0] idx, input logic [7:0] d);
      logic [1:0] r;
      axiWrite(idx, d, 4'hF, r);
      check(r, RCMR_RESP_OKAY);
   endtask : writeOk

   task automatic readCheck(input logic [15:0] idx, input logic [7:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      axiRead(idx, d, r);
      check(d, {24'h0, exp});
      check(r, RCMR_RESP_OKAY);
   endtask : readCheck

   function automatic logic srcOf(input logic [5:0] sel);
      case (sel)
         RCMR_SEL_TX_ACTIVE: return txActive;
         RCMR_SEL_RX_ACTIVE: return rxActive;
         RCMR_SEL_ENGINE_IDLE: return engineIdleIn && !engineReset;
         default: return radioCoreSignals[sel];
      endcase
   endfunction : srcOf

   // ------
   // Scenarios
   // ------
   task automatic testResetValues();
      readCheck(RCMR_IDX_OBS1, 8'h00);
      readCheck(RCMR_IDX_OBS2, 8'h00);
      readCheck(RCMR_IDX_ENGINE, 8'h00);
      readCheck(RCMR_IDX_FILTER, 8'h0F);
      readCheck(RCMR_IDX_RANDOM, 8'h00);
      readCheck(RCMR_IDX_PAGE, 8'h08);
      check(txFilterBandwidth, 2'h3);
      check(radioMemoryPage, 3'h0);
      check(engineReset, 1'b1);
   endtask : testResetValues

   task automatic testObserve();
      logic [7:0] ctl [5] = '{8'h09, 8'h4A, 8'h05, 8'h0D, 8'hFF};
      for (int i = 0; i < 5; i++) begin
         writeOk(RCMR_IDX_OBS1, ctl[i]);
         writeOk(RCMR_IDX_OBS2, ctl[i] ^ 8'h40);
         repeat (2) @(posedge clk);
         check(observeOut1, srcOf(ctl[i][5:0]) ^ ctl[i][6]);
         check(observeOut2, srcOf(ctl[i][5:0]) ^ !ctl[i][6]);
         readCheck(RCMR_IDX_OBS1, ctl[i] & 8'h7F);
         readCheck(RCMR_IDX_OBS2, (ctl[i] ^ 8'h40) & 8'h7F);
      end
   endtask : testObserve

   task automatic testEngine();
      writeOk(RCMR_IDX_ENGINE, 8'h02);
      repeat (3) @(posedge clk);
      check(engineMode, RCMR_MODE_PROPRIETARY);
      check(engineReset, 1'b1);
      readCheck(RCMR_IDX_ENGINE, 8'h02);
      writeOk(RCMR_IDX_ENGINE, 8'h03);
      writeOk(RCMR_IDX_OBS1, RCMR_SEL_ENGINE_IDLE);
      repeat (2) @(posedge clk);
      check(engineReset, 1'b0);
      check(engineMode, RCMR_MODE_LOW_ENERGY);
      check(engineModeLowEnergy, 1'b1);
      check(engineModeProprietary, 1'b0);
      check(observeOut1, 1'b1);
      writeOk(RCMR_IDX_ENGINE, 8'hF9);
      repeat (3) @(posedge clk);
      check(engineMode, RCMR_MODE_LOW_ENERGY);
      readCheck(RCMR_IDX_ENGINE, 8'h01);
      writeOk(RCMR_IDX_ENGINE, 8'h00);
      repeat (2) @(posedge clk);
      check(engineReset, 1'b1);
      check(observeOut1, 1'b0);
      writeOk(RCMR_IDX_ENGINE, 8'h05);
      repeat (3) @(posedge clk);
      check(engineMode, RCMR_MODE_RSVD_2);
      check(engineModeReserved, 1'b1);
      writeOk(RCMR_IDX_ENGINE, 8'h00);
      writeOk(RCMR_IDX_ENGINE, 8'h07);
      repeat (3) @(posedge clk);
      check(engineMode, RCMR_MODE_RSVD_3);
      writeOk(RCMR_IDX_ENGINE, 8'h00);
      writeOk(RCMR_IDX_ENGINE, 8'h01);
      repeat (3) @(posedge clk);
      check(engineModeProprietary, 1'b1);
      writeOk(RCMR_IDX_ENGINE, 8'h00);
   endtask : testEngine

   task automatic testFilterPage();
      logic [1:0] r;
      writeOk(RCMR_IDX_FILTER, 8'hF0);
      repeat (2) @(posedge clk);
      check(txFilterBandwidth, 2'h0);
      readCheck(RCMR_IDX_FILTER, 8'h00);
      writeOk(RCMR_IDX_FILTER, 8'h06);
      axiWrite(RCMR_IDX_FILTER, 8'h01, 4'h0, r);
      check(r, RCMR_RESP_OKAY);
      readCheck(RCMR_IDX_FILTER, 8'h06);
      check(txFilterBandwidth, 2'h2);
      writeOk(RCMR_IDX_PAGE, 8'hFD);
      readCheck(RCMR_IDX_PAGE, 8'h0D);
      check(radioMemoryPage, 3'h5);
      writeOk(RCMR_IDX_PAGE, 8'h07);
      readCheck(RCMR_IDX_PAGE, 8'h0F);
      check(radioMemoryPage, 3'h7);
   endtask : testFilterPage

   task automatic testRandomUnmapped();
      logic [31:0] d;
      logic [1:0] r;
      @(posedge clk);
      randomBitsIn <= 8'hA5;
      randomValid <= 1'b1;
      @(posedge clk);
      randomBitsIn <= 8'h3C;
      randomValid <= 1'b0;
      readCheck(RCMR_IDX_RANDOM, 8'hA5);
      writeOk(RCMR_IDX_RANDOM, 8'h11);
      readCheck(RCMR_IDX_RANDOM, 8'hA5);
      axiWrite(16'h61B2, 8'h55, 4'hF, r);
      check(r, RCMR_RESP_SLVERR);
      axiRead(16'h61B2, d, r);
      check(d, 32'h0);
      check(r, RCMR_RESP_SLVERR);
   endtask : testRandomUnmapped

   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      testResetValues();
      testObserve();
      testEngine();
      testFilterPage();
      testRandomUnmapped();
      endOfTest();
   end
endmodule : tb

bind rcmr_regs rcmr_regs_checker rcmr_regs_checker_inst (.*);
